// ### rtl/uiecfe_pkg.sv
package uiecfe_pkg;
    localparam int          NUM_EP           = 4;
    localparam int          IRQ_W            = 4;
    localparam logic [11:0] OFF_ALL_EP_IRQ    = 12'h818;
    localparam logic [11:0] OFF_ALL_EP_IRQ_EN = 12'h81C;
    localparam logic [11:0] OFF_FE_IRQ_EN     = 12'h834;
    localparam logic [11:0] OFF_EP0_CTL       = 12'h900;
    localparam logic [11:0] OFF_IRQ_STATUS    = 12'hA00;
    localparam logic [11:0] OFF_IRQ_MASK      = 12'hA04;
    localparam int          CTL_EN_BIT       = 31;
    localparam int          CTL_DIS_BIT      = 30;
    localparam int          CTL_NSET_BIT     = 27;
    localparam int          CTL_NCLR_BIT     = 26;
    localparam int          CTL_TXF_LSB      = 22;
    localparam int          CTL_TXF_MSB      = 25;
    localparam int          CTL_STALL_BIT    = 21;
    localparam int          CTL_PKL_MSB      = 1;
    localparam logic [31:0] CTL_RST          = 32'h00008000;
    localparam logic [31:0] FE_IRQ_EN_RST    = 32'h00000000;
    localparam logic [1:0]  EP_TYPE_CTRL     = 2'h0;
    localparam logic        EP_ACTIVE_VAL    = 1'h1;
    localparam logic [6:0]  PKL_BYTES_00     = 7'h40;
    localparam logic [6:0]  PKL_BYTES_01     = 7'h20;
    localparam logic [6:0]  PKL_BYTES_10     = 7'h10;
    localparam logic [6:0]  PKL_BYTES_11     = 7'h08;
    localparam int          IRQ_DISABLED     = 0;
    localparam int          IRQ_STALL_CLR    = 1;
    localparam int          IRQ_STALL_SENT   = 2;
    localparam int          IRQ_NAK_SENT     = 3;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    typedef enum logic [1:0] {
        HS_NONE  = 2'h0,
        HS_DATA  = 2'h1,
        HS_NAK   = 2'h3,
        HS_STALL = 2'h2
    } uiecfe_hs_e;
endpackage

// ### rtl/uiecfe_top.sv
// Our own choice: register access over AXI4-Lite.
module uiecfe_top
(
    input  wire logic        clk_sys,              // System clock
    input  wire logic        rst_n,                // Async reset
    input  wire logic [11:0] s_axi_awaddr,         // Write address
    input  wire logic        s_axi_awvalid,        // Write address valid
    output logic             s_axi_awready,        // Write address ready
    input  wire logic [31:0] s_axi_wdata,          // Write data
    input  wire logic [3:0]  s_axi_wstrb,          // Write strobes
    input  wire logic        s_axi_wvalid,         // Write data valid
    output logic             s_axi_wready,         // Write data ready
    output logic [1:0]       s_axi_bresp,          // Write response
    output logic             s_axi_bvalid,         // Write response valid
    input  wire logic        s_axi_bready,         // Write response ready
    input  wire logic [11:0] s_axi_araddr,         // Read address
    input  wire logic        s_axi_arvalid,        // Read address valid
    output logic             s_axi_arready,        // Read address ready
    output logic [31:0]      s_axi_rdata,          // Read data
    output logic [1:0]       s_axi_rresp,          // Read response
    output logic             s_axi_rvalid,         // Read data valid
    input  wire logic        s_axi_rready,         // Read data ready
    input  wire logic        in_token_ep0,         // IN token on EP0
    input  wire logic        setup_token_ep0,      // SETUP on OUT EP0
    input  wire logic        ep0_xfer_done,        // EP0 transfer ended
    input  wire logic        global_in_nak_status, // Global IN NAK
    input  wire logic [3:0]  tx_fifo_empty_flag,   // Per-FIFO empty
    output logic             hs_valid,             // Handshake strobe
    output logic [1:0]       hs_code,              // Handshake kind
    output logic [3:0]       tx_fifo_select,       // FIFO for EP0
    output logic [6:0]       max_packet_len_bytes, // Decoded length
    output logic             ep_enable,            // EP0 enabled
    output logic             ep_stall,             // EP0 stalled
    output logic             nak_status,           // EP0 NAK status
    output logic             in_ep_global_irq,     // Global IN flag
    output logic             irq                   // Interrupt line
);

    localparam int IRQ_W = uiecfe_pkg::IRQ_W;
    logic              awready_reg;
    logic              wready_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [1:0]        rresp_reg;
    logic [31:0]       rdata_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [11:0]       aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;

    logic              ep_en_reg;
    logic              ep_dis_reg;
    logic              nak_reg;
    logic              stall_reg;
    logic [3:0]        txf_sel_reg;
    logic [1:0]        pkl_reg;
    logic [6:0]        pkl_bytes_reg;
    logic [3:0]        fe_en_reg;
    logic [3:0]        all_en_reg;
    logic [3:0]        all_irq_reg;
    logic              glob_irq_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic              irq_reg;
    logic              hs_valid_reg;
    uiecfe_pkg::uiecfe_hs_e hs_code_reg;

    logic              aw_take;
    logic              w_take;
    logic              do_write;
    logic              do_read;
    logic              aw_full_next;
    logic              w_full_next;
    logic              bvalid_next;
    logic              rvalid_next;

    assign aw_take = s_axi_awvalid & awready_reg;
    assign w_take = s_axi_wvalid & wready_reg;
    assign do_write = aw_full_reg & w_full_reg
                    & (~bvalid_reg | s_axi_bready);
    assign do_read = s_axi_arvalid & arready_reg;
    assign aw_full_next = (aw_full_reg & ~do_write) | aw_take;
    assign w_full_next = (w_full_reg & ~do_write) | w_take;
    assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    assign rvalid_next = do_read | (rvalid_reg & ~s_axi_rready);

    logic [31:0]       wr_mask;
    logic [31:0]       wr_bits;
    logic              wr_ctl;
    logic              wr_fe;
    logic              wr_all_en;
    logic              wr_stat;
    logic              wr_mask_reg;
    logic              wr_hit;

    assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_bits = w_data_reg & wr_mask;
    assign wr_ctl = do_write & (aw_addr_reg == uiecfe_pkg::OFF_EP0_CTL);
    assign wr_fe = do_write & (aw_addr_reg == uiecfe_pkg::OFF_FE_IRQ_EN);
    assign wr_all_en = do_write
                     & (aw_addr_reg == uiecfe_pkg::OFF_ALL_EP_IRQ_EN);
    assign wr_stat = do_write
                   & (aw_addr_reg == uiecfe_pkg::OFF_IRQ_STATUS);
    assign wr_mask_reg = do_write
                       & (aw_addr_reg == uiecfe_pkg::OFF_IRQ_MASK);
    assign wr_hit = wr_ctl | wr_fe | wr_all_en | wr_stat | wr_mask_reg
                  | (aw_addr_reg == uiecfe_pkg::OFF_ALL_EP_IRQ);

    // Command bits from software
    logic              sw_en_set;
    logic              sw_dis_set;
    logic              sw_nset;
    logic              sw_nclr;
    logic              sw_stall_set;

    assign sw_en_set = wr_ctl & wr_bits[uiecfe_pkg::CTL_EN_BIT];
    assign sw_dis_set = wr_ctl & wr_bits[uiecfe_pkg::CTL_DIS_BIT];
    assign sw_nset = wr_ctl & wr_bits[uiecfe_pkg::CTL_NSET_BIT];
    assign sw_nclr = wr_ctl & wr_bits[uiecfe_pkg::CTL_NCLR_BIT];
    assign sw_stall_set = wr_ctl & wr_bits[uiecfe_pkg::CTL_STALL_BIT];

    // Next values of control fields
    logic              ep_en_next;
    logic              ep_dis_next;
    logic              nak_next;
    logic              stall_next;
    logic [3:0]        txf_sel_next;
    logic [1:0]        pkl_next;
    logic [6:0]        pkl_bytes_next;
    logic [3:0]        fe_en_next;
    logic [3:0]        all_en_next;
    logic [IRQ_W-1:0]  irq_mask_next;
    logic [IRQ_W-1:0]  irq_stat_next;
    logic [IRQ_W-1:0]  irq_event;
    logic [IRQ_W-1:0]  irq_w1c;
    logic              dev_clr_en;

    // Device clears enable after a disable or at transfer end
    assign dev_clr_en = ep_dis_reg | ep0_xfer_done;
    assign ep_en_next = sw_en_set | (ep_en_reg & ~dev_clr_en);
    assign ep_dis_next = sw_dis_set;
    assign nak_next = sw_nset | (nak_reg & ~sw_nclr);
    assign stall_next = sw_stall_set
                      | (stall_reg & ~setup_token_ep0);

    localparam int TXF_L = uiecfe_pkg::CTL_TXF_LSB;
    localparam int TXF_M = uiecfe_pkg::CTL_TXF_MSB;
    localparam int PKL_M = uiecfe_pkg::CTL_PKL_MSB;

    assign txf_sel_next = wr_ctl
        ? ((txf_sel_reg & ~wr_mask[TXF_M:TXF_L]) | wr_bits[TXF_M:TXF_L])
        : txf_sel_reg;
    assign pkl_next = wr_ctl
        ? ((pkl_reg & ~wr_mask[PKL_M:0]) | wr_bits[PKL_M:0])
        : pkl_reg;
    assign fe_en_next = wr_fe
        ? ((fe_en_reg & ~wr_mask[3:0]) | wr_bits[3:0])
        : fe_en_reg;
    assign all_en_next = wr_all_en
        ? ((all_en_reg & ~wr_mask[3:0]) | wr_bits[3:0])
        : all_en_reg;
    assign irq_mask_next = wr_mask_reg
        ? ((irq_mask_reg & ~wr_mask[IRQ_W-1:0]) | wr_bits[IRQ_W-1:0])
        : irq_mask_reg;

    assign pkl_bytes_next = (pkl_next == 2'h0) ? uiecfe_pkg::PKL_BYTES_00
                          : (pkl_next == 2'h1) ? uiecfe_pkg::PKL_BYTES_01
                          : (pkl_next == 2'h2) ? uiecfe_pkg::PKL_BYTES_10
                          : uiecfe_pkg::PKL_BYTES_11;

    // Answer to an IN token
    logic              sel_empty;
    logic              force_nak;
    uiecfe_pkg::uiecfe_hs_e hs_pick;

    assign sel_empty = (txf_sel_reg[3:2] != 2'h0)
                     | tx_fifo_empty_flag[txf_sel_reg[1:0]];
    assign force_nak = global_in_nak_status | nak_reg
                     | ~ep_en_reg | sel_empty;
    assign hs_pick = stall_reg ? uiecfe_pkg::HS_STALL
                   : force_nak ? uiecfe_pkg::HS_NAK
                   : uiecfe_pkg::HS_DATA;

    // Sticky event bits, set wins over write-one-clear
    assign irq_event[uiecfe_pkg::IRQ_DISABLED] = ep_dis_reg & ep_en_reg;
    assign irq_event[uiecfe_pkg::IRQ_STALL_CLR] = setup_token_ep0
                                                & stall_reg;
    assign irq_event[uiecfe_pkg::IRQ_STALL_SENT] = in_token_ep0
        & (hs_pick == uiecfe_pkg::HS_STALL);
    assign irq_event[uiecfe_pkg::IRQ_NAK_SENT] = in_token_ep0
        & (hs_pick == uiecfe_pkg::HS_NAK);
    assign irq_w1c = wr_stat ? wr_bits[IRQ_W-1:0] : {IRQ_W{1'b0}};
    assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_event;

    // Per-endpoint FIFO-empty interrupt gating
    logic [3:0]        ep_irq_w;

    genvar gi;
    generate
        for (gi = 0; gi < uiecfe_pkg::NUM_EP; gi++)
        begin : g_ep
            assign ep_irq_w[gi] = tx_fifo_empty_flag[gi]
                                & fe_en_reg[gi];
        end
    endgenerate

    logic [31:0]       ctl_rd;
    logic [31:0]       rd_word;
    logic              rd_hit;

    assign ctl_rd = {ep_en_reg, ep_dis_reg, 2'h0, 2'h0, txf_sel_reg,
                     stall_reg, 1'b0,
                     uiecfe_pkg::EP_TYPE_CTRL,
                     nak_reg, 1'b0,
                     uiecfe_pkg::EP_ACTIVE_VAL,
                     13'h0000, pkl_reg};
    assign rd_hit = (s_axi_araddr == uiecfe_pkg::OFF_EP0_CTL)
                  | (s_axi_araddr == uiecfe_pkg::OFF_FE_IRQ_EN)
                  | (s_axi_araddr == uiecfe_pkg::OFF_ALL_EP_IRQ)
                  | (s_axi_araddr == uiecfe_pkg::OFF_ALL_EP_IRQ_EN)
                  | (s_axi_araddr == uiecfe_pkg::OFF_IRQ_STATUS)
                  | (s_axi_araddr == uiecfe_pkg::OFF_IRQ_MASK);
    assign rd_word =
        (s_axi_araddr == uiecfe_pkg::OFF_EP0_CTL) ? ctl_rd
      : (s_axi_araddr == uiecfe_pkg::OFF_FE_IRQ_EN) ? {28'h0, fe_en_reg}
      : (s_axi_araddr == uiecfe_pkg::OFF_ALL_EP_IRQ) ? {28'h0, all_irq_reg}
      : (s_axi_araddr == uiecfe_pkg::OFF_ALL_EP_IRQ_EN)
        ? {28'h0, all_en_reg}
      : (s_axi_araddr == uiecfe_pkg::OFF_IRQ_STATUS)
        ? {{(32-IRQ_W){1'b0}}, irq_stat_reg}
      : (s_axi_araddr == uiecfe_pkg::OFF_IRQ_MASK)
        ? {{(32-IRQ_W){1'b0}}, irq_mask_reg}
      : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= uiecfe_pkg::RESP_OKAY;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= ~aw_full_next;
            wready_reg <= ~w_full_next;
            bvalid_reg <= bvalid_next;
            if (do_write)
            begin
                bresp_reg <= wr_hit ? uiecfe_pkg::RESP_OKAY
                                    : uiecfe_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= uiecfe_pkg::RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (do_read)
            begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? uiecfe_pkg::RESP_OKAY
                                    : uiecfe_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ep_en_reg <= uiecfe_pkg::CTL_RST[uiecfe_pkg::CTL_EN_BIT];
            ep_dis_reg <= uiecfe_pkg::CTL_RST[uiecfe_pkg::CTL_DIS_BIT];
            nak_reg <= 1'b0;
            stall_reg <= uiecfe_pkg::CTL_RST[uiecfe_pkg::CTL_STALL_BIT];
            txf_sel_reg <= uiecfe_pkg::CTL_RST[TXF_M:TXF_L];
            pkl_reg <= uiecfe_pkg::CTL_RST[PKL_M:0];
            pkl_bytes_reg <= uiecfe_pkg::PKL_BYTES_00;
        end
        else
        begin
            ep_en_reg <= ep_en_next;
            ep_dis_reg <= ep_dis_next;
            nak_reg <= nak_next;
            stall_reg <= stall_next;
            txf_sel_reg <= txf_sel_next;
            pkl_reg <= pkl_next;
            pkl_bytes_reg <= pkl_bytes_next;
        end
    end

    // Interrupt enables and flags
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fe_en_reg <= uiecfe_pkg::FE_IRQ_EN_RST[3:0];
            all_en_reg <= 4'h0;
            all_irq_reg <= 4'h0;
            glob_irq_reg <= 1'b0;
            irq_mask_reg <= {IRQ_W{1'b0}};
            irq_stat_reg <= {IRQ_W{1'b0}};
            irq_reg <= 1'b0;
        end
        else
        begin
            fe_en_reg <= fe_en_next;
            all_en_reg <= all_en_next;
            all_irq_reg <= ep_irq_w;
            glob_irq_reg <= |(ep_irq_w & all_en_reg);
            irq_mask_reg <= irq_mask_next;
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_mask_next);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_valid_reg <= 1'b0;
            hs_code_reg <= uiecfe_pkg::HS_NONE;
        end
        else
        begin
            hs_valid_reg <= in_token_ep0;
            hs_code_reg <= in_token_ep0 ? hs_pick : uiecfe_pkg::HS_NONE;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign hs_valid = hs_valid_reg;
    assign hs_code = hs_code_reg;
    assign tx_fifo_select = txf_sel_reg;
    assign max_packet_len_bytes = pkl_bytes_reg;
    assign ep_enable = ep_en_reg;
    assign ep_stall = stall_reg;
    assign nak_status = nak_reg;
    assign in_ep_global_irq = glob_irq_reg;
    assign irq = irq_reg;

endmodule // uiecfe_top

// ### verif/uiecfe_host_model.sv
module uiecfe_host_model
(
    input  wire logic clk_sys,        // Clock
    input  wire logic rst_n,          // Reset
    input  wire logic send_in,        // Request IN token
    input  wire logic send_setup,     // Request SETUP token
    output logic      in_token_ep0,   // IN token pulse
    output logic      setup_token_ep0 // SETUP token pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_token_ep0    <= 1'b0;
            setup_token_ep0 <= 1'b0;
        end
        else
        begin
            in_token_ep0    <= send_in;
            setup_token_ep0 <= send_setup;
        end
    end
endmodule // uiecfe_host_model

// ### verif/uiecfe_monitor.sv
module uiecfe_monitor
(
    input wire logic        clk_sys,              // Clock
    input wire logic        rst_n,                // Reset
    input wire logic        s_axi_awready,        // AW ready
    input wire logic        s_axi_bvalid,         // B valid
    input wire logic        s_axi_rvalid,         // R valid
    input wire logic        s_axi_rready,         // R ready
    input wire logic [31:0] s_axi_rdata,          // R data
    input wire logic        in_token_ep0,         // IN token
    input wire logic        setup_token_ep0,      // SETUP token
    input wire logic        ep0_xfer_done,        // Transfer end
    input wire logic        global_in_nak_status, // Global NAK
    input wire logic [3:0]  tx_fifo_empty_flag,   // FIFO empty
    input wire logic        hs_valid,             // Handshake strobe
    input wire logic [1:0]  hs_code,              // Handshake kind
    input wire logic [3:0]  tx_fifo_select,       // FIFO select
    input wire logic [6:0]  max_packet_len_bytes, // Packet length
    input wire logic        ep_enable,            // Enabled
    input wire logic        ep_stall,             // Stalled
    input wire logic        nak_status            // NAK status
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_hs_answer: assert property (in_token_ep0 |=> hs_valid && hs_code != 2'h0)
        else $error("no handshake after token");
    a_stall_first: assert property (in_token_ep0 && ep_stall
        |=> hs_code == uiecfe_pkg::HS_STALL) else $error("stall not sent");
    a_nak_answer: assert property (in_token_ep0 && !ep_stall
        && (nak_status || global_in_nak_status)
        |=> hs_code == uiecfe_pkg::HS_NAK) else $error("nak not sent");
    a_data_answer: assert property (in_token_ep0 && !ep_stall
        && !nak_status && !global_in_nak_status && ep_enable
        && tx_fifo_select < 4'h4 && !tx_fifo_empty_flag[tx_fifo_select[1:0]]
        |=> hs_code == uiecfe_pkg::HS_DATA) else $error("data not sent");
    a_setup_unstall: assert property (setup_token_ep0 && s_axi_awready
        |=> !ep_stall) else $error("stall kept after setup");
    a_enable_source: assert property ($rose(ep_enable)
        |-> $rose(s_axi_bvalid)) else $error("enable set without write");
    a_done_clears: assert property (ep0_xfer_done && s_axi_awready
        |=> !ep_enable) else $error("enable kept after transfer end");
    a_nak_source: assert property ($changed(nak_status)
        |-> $rose(s_axi_bvalid)) else $error("nak status changed alone");
    a_pkl_code: assert property (max_packet_len_bytes[2:0] == 3'h0
        && $onehot(max_packet_len_bytes[6:3])) else $error("bad length");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");

    c_stall_tok: cover property (in_token_ep0 && ep_stall);
    c_setup_clr: cover property (setup_token_ep0 && ep_stall);
    c_disable:   cover property ($fell(ep_enable));
endmodule // uiecfe_monitor

bind uiecfe_top uiecfe_monitor u_uiecfe_monitor (.clk_sys, .rst_n,
    .s_axi_awready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .in_token_ep0, .setup_token_ep0, .ep0_xfer_done, .global_in_nak_status,
    .tx_fifo_empty_flag, .hs_valid, .hs_code, .tx_fifo_select,
    .max_packet_len_bytes, .ep_enable, .ep_stall, .nak_status);

// ### verif/uiecfe_top_tb.sv
module uiecfe_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, tx_fifo_empty_flag, tx_fifo_select;
    logic [1:0]  s_axi_bresp, s_axi_rresp, hs_code, m_pkl;
    logic [6:0]  max_packet_len_bytes;
    logic [3:0]  m_txf, m_fe, m_alle, m_stat, m_mask;
    logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, in_token_ep0;
    logic        setup_token_ep0, ep0_xfer_done, global_in_nak_status;
    logic        hs_valid, ep_enable, ep_stall, nak_status, in_ep_global_irq;
    logic        irq, send_in, send_setup, m_en, m_nak, m_stall;
    int          mismatches, tests_run, i;

    uiecfe_top u_uiecfe_top (.*);
    uiecfe_host_model u_uiecfe_host_model (.*);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] m_ctl();
        return {m_en, 5'h0, m_txf, m_stall, 3'h0, m_nak, 2'h1, 13'h0, m_pkl};
    endfunction
    function automatic logic [31:0] kp();
        return {6'h0, m_txf, 20'h0, m_pkl};
    endfunction
    function automatic logic [1:0] m_hs();
        if (m_stall) return uiecfe_pkg::HS_STALL;
        if (global_in_nak_status || m_nak || !m_en || m_txf > 4'h3
            || tx_fifo_empty_flag[m_txf[1:0]]) return uiecfe_pkg::HS_NAK;
        return uiecfe_pkg::HS_DATA;
    endfunction

    task automatic report_and_stop();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            mismatches++;
        end
    endtask
    task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
        chk_reg({24'h0, g}, {24'h0, e});
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                chk_reg({30'h0, s_axi_bresp}, {30'h0, er});
                break;
            end
        end
        if (n == 50) begin mismatches++; report_and_stop(); end
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                chk_reg(s_axi_rdata, e);
                chk_reg({30'h0, s_axi_rresp}, {30'h0, er});
                break;
            end
        end
        if (n == 50) begin mismatches++; report_and_stop(); end
    endtask
    task automatic wctl(input logic [31:0] d);
        axw(uiecfe_pkg::OFF_EP0_CTL, d, uiecfe_pkg::RESP_OKAY);
        if (d[31]) m_en = 1'b1;
        if (d[27]) m_nak = 1'b1;
        else if (d[26]) m_nak = 1'b0;
        if (d[21]) m_stall = 1'b1;
        m_txf = d[25:22];
        m_pkl = d[1:0];
        if (d[30] && m_en) begin m_en = 1'b0; m_stat[0] = 1'b1; end
    endtask
    task automatic pins();
        #1;
        chk_pin({m_en, m_stall, m_nak, 1'b0, m_txf}, {ep_enable, ep_stall,
                nak_status, 1'b0, tx_fifo_select});
        chk_pin({1'b0, max_packet_len_bytes}, 8'h40 >> m_pkl);
        chk_pin({7'h0, irq}, {7'h0, |(m_stat & m_mask)});
    endtask
    task automatic tok();
        logic [1:0] e;
        @(posedge clk_sys) send_in <= 1'b1;
        @(posedge clk_sys) send_in <= 1'b0;
        e = m_hs();
        m_stat |= {e == uiecfe_pkg::HS_NAK, e == uiecfe_pkg::HS_STALL, 2'h0};
        @(posedge clk_sys);
        #1 chk_pin({5'h0, hs_valid, hs_code}, {5'h0, 1'b1, e});
    endtask

    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {ep0_xfer_done, global_in_nak_status, send_in, send_setup} = '0;
        {m_en, m_nak, m_stall, m_txf, m_fe, m_alle, m_stat, m_mask} = '0;
        {rst_n, m_pkl, mismatches, tests_run} = '0;
        s_axi_wstrb = 4'hF;
        tx_fifo_empty_flag = 4'hF;
        void'($urandom(32'h16f0));
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        axr(uiecfe_pkg::OFF_EP0_CTL, 32'h00008000, 2'h0);
        axr(uiecfe_pkg::OFF_FE_IRQ_EN, 32'h0, 2'h0);
        axr(12'h100, 32'h0, uiecfe_pkg::RESP_SLVERR);
        axw(12'h104, 32'hFFFFFFFF, uiecfe_pkg::RESP_SLVERR);
        axw(uiecfe_pkg::OFF_FE_IRQ_EN, 32'hFFFFFFFF, 2'h0);
        axr(uiecfe_pkg::OFF_FE_IRQ_EN, 32'hF, 2'h0);
        axw(uiecfe_pkg::OFF_ALL_EP_IRQ_EN, 32'h5, 2'h0);
        m_alle = 4'h5;
        for (i = 0; i < 4; i++)
        begin
            axw(uiecfe_pkg::OFF_FE_IRQ_EN, 32'h1 << i, 2'h0);
            m_fe = 4'h1 << i;
            repeat (2) @(posedge clk_sys);
            #1 chk_pin({7'h0, in_ep_global_irq}, {7'h0, m_alle[i]});
            axr(uiecfe_pkg::OFF_ALL_EP_IRQ, {28'h0, m_fe}, 2'h0);
        end
        for (i = 0; i < 4; i++)
        begin
            wctl(32'hB01FFFFC | (i << 22) | i);
            pins();
            axr(uiecfe_pkg::OFF_EP0_CTL, m_ctl(), 2'h0);
        end
        @(posedge clk_sys) tx_fifo_empty_flag <= 4'h0;
        tok();
        wctl(kp() | 32'h08000000);
        pins();
        tok();
        wctl(kp() | 32'h0C000000);
        pins();
        wctl(kp() | 32'h04000000);
        pins();
        tok();
        @(posedge clk_sys) global_in_nak_status <= 1'b1;
        tok();
        wctl(kp() | 32'h08200000);
        tok();
        wctl(kp() | 32'h04000000);
        pins();
        @(posedge clk_sys) send_setup <= 1'b1;
        @(posedge clk_sys) send_setup <= 1'b0;
        repeat (2) @(posedge clk_sys);
        {m_stall, m_stat[1]} = 2'h1;
        pins();
        tok();
        axw(uiecfe_pkg::OFF_IRQ_MASK, 32'hF, 2'h0);
        m_mask = 4'hF;
        pins();
        axr(uiecfe_pkg::OFF_IRQ_STATUS, {28'h0, m_stat}, 2'h0);
        axw(uiecfe_pkg::OFF_IRQ_STATUS, 32'hF, 2'h0);
        m_stat = 4'h0;
        pins();
        for (i = 0; i < 24; i++)
        begin
            if (i % 4 == 0) wctl(($urandom & 32'h0FC00003) | 32'h80000000);
            tx_fifo_empty_flag <= 4'($urandom);
            global_in_nak_status <= 1'($urandom);
            tok();
        end
        pins();
        @(posedge clk_sys) ep0_xfer_done <= 1'b1;
        @(posedge clk_sys) ep0_xfer_done <= 1'b0;
        @(posedge clk_sys) m_en = 1'b0;
        pins();
        wctl(kp() | 32'h80000000);
        wctl(kp() | 32'h40000000);
        axr(uiecfe_pkg::OFF_EP0_CTL, m_ctl(), 2'h0);
        pins();
        tok();
        report_and_stop();
    end
endmodule // uiecfe_top_tb
